/* design/dual_switch_mode_control.sv */
// Operating-mode state machine for a dual-channel high-side switch.
// Assumes pin inputs synchronous to mclk and an Avalon-MM master.
// Function
// - Unpowered device stays off, nothing works
// - Standby saves power, no diagnostics
// - Diagnostic state runs checks, switches off
// - All enables low enters standby delay
// - Delay expired, inputs low: go standby
// - Active whenever a switch is enabled
// - Diagnostics toggle freely while staying active
// - Thermal or current-limit shutdown enters fault
// - Leave fault: cleared, latch low, retry expired
// - After fault, enabled channel turns back on
// - After fault, disabled channel stays off
// - Channels follow only their own enable
// - One channel's fault leaves other untouched
// - Open-load flag clears on diag fall, enable rise
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ns

module dual_switch_mode_control #(
	parameter int unsigned STANDBY_COUNT = switch_mode_pkg::STANDBY_CYCLES,
	parameter int unsigned RETRY_COUNT   = switch_mode_pkg::RETRY_CYCLES
) (
	// Clock and reset
	input  wire logic                              mclk,
	input  wire logic                              rst,
	// Host pins
	input  wire logic                              channel_one_enable,
	input  wire logic                              channel_two_enable,
	input  wire logic                              diagnostic_enable,
	input  wire logic                              latch_select,
	// Supply and analog monitors
	input  wire logic                              power_good,
	input  wire switch_mode_pkg::chan_fault_type [1:0] chan_fault,
	// Switch drive and state
	output logic                                   [1:0] switch_on,
	output logic                                   [1:0] fault_indication,
	output logic                                   [1:0] open_load_flag,
	output switch_mode_pkg::mode_type              mode,
	// Avalon-MM slave
	input  wire logic                              [3:0] address,
	input  wire logic                              read,
	input  wire logic                              write,
	input  wire logic                              [31:0] writedata,
	input  wire logic                              [3:0] byteenable,
	output logic                                   [31:0] readdata,
	output logic                                   waitrequest,
	// Interrupt
	output logic                                   irq
);
	import switch_mode_pkg::*;

	mode_type         mode_reg, mode_next;
	logic [31:0]      stby_cnt_reg, stby_cnt_next;
	ch_type           ch_reg [2];
	logic [1:0]       en_now;
	logic [1:0]       en_prev_reg;
	logic             diag_prev_reg;
	logic [1:0]       ch_fault_set;
	logic [1:0]       open_set;
	logic             latch_eff;
	logic             stby_done;
	logic             ctrl_latch_reg, ctrl_latch_next;
	logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
	logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
	logic             resp_reg, resp_next;
	logic [31:0]      rdata_reg, rdata_next;
	logic [IRQ_W-1:0] events;
	logic             bus_wr;

	assign en_now    = {channel_two_enable, channel_one_enable};
	assign latch_eff = latch_select | ctrl_latch_reg;
	assign stby_done = (stby_cnt_reg == 32'(STANDBY_COUNT - 1));

	// Device mode
	always_comb begin
		mode_next     = mode_reg;
		stby_cnt_next = 32'h0000_0000;
		if (!power_good) begin
			mode_next = MODE_OFF;
		end else if (en_now != 2'b00) begin
			mode_next = MODE_ACTIVE;
		end else if (diagnostic_enable) begin
			mode_next = MODE_DIAG;
		end else begin
			unique case (mode_reg)
				MODE_OFF, MODE_ACTIVE, MODE_DIAG: begin
					mode_next = MODE_STBY_DL;
				end
				MODE_STBY_DL: begin
					stby_cnt_next = stby_cnt_reg + 32'h0000_0001;
					if (stby_done) begin
						mode_next = MODE_STANDBY;
					end
				end
				MODE_STANDBY: begin
					mode_next = MODE_STANDBY;
				end
				default: begin
					mode_next = MODE_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			mode_reg      <= MODE_OFF;
			stby_cnt_reg  <= 32'h0000_0000;
			en_prev_reg   <= 2'b00;
			diag_prev_reg <= 1'b0;
		end else begin
			mode_reg      <= mode_next;
			stby_cnt_reg  <= stby_cnt_next;
			en_prev_reg   <= en_now;
			diag_prev_reg <= diagnostic_enable;
		end
	end

	assign mode = mode_reg;

	// Per-channel switch, fault and open-load logic, no cross terms between channels
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ch
			ch_type      st_next;
			logic [31:0] retry_reg, retry_next;
			logic        ol_reg, ol_next;
			logic        shutdown;
			logic        retry_done;

			assign shutdown   = chan_fault[gi].thermal_shutdown | chan_fault[gi].current_limit;
			assign retry_done = (retry_reg == 32'(RETRY_COUNT - 1));

			always_comb begin
				st_next    = ch_reg[gi];
				retry_next = 32'h0000_0000;
				if (!power_good) begin
					st_next = CH_OFF;
				end else begin
					unique case (ch_reg[gi])
						CH_OFF: begin
							st_next = en_now[gi] ? CH_ON : CH_OFF;
						end
						CH_ON: begin
							if (shutdown) begin
								st_next = CH_FAULT;
							end else if (!en_now[gi]) begin
								st_next = CH_OFF;
							end
						end
						CH_FAULT: begin
							retry_next = retry_done ? retry_reg : retry_reg + 32'h0000_0001;
							if (!shutdown && !latch_eff && retry_done) begin
								st_next = en_now[gi] ? CH_ON : CH_OFF;
							end
						end
						default: begin
							st_next = CH_OFF;
						end
					endcase
				end
			end

			// Detection only while diagnostics run and this switch is off
			always_comb begin
				ol_next = ol_reg;
				if (mode_reg == MODE_OFF || mode_reg == MODE_STANDBY) begin
					ol_next = 1'b0;
				end else if ((diag_prev_reg && !diagnostic_enable)
						|| (en_now[gi] && !en_prev_reg[gi])) begin
					ol_next = 1'b0;
				end else if (diagnostic_enable && !en_now[gi] && ch_reg[gi] == CH_OFF) begin
					ol_next = chan_fault[gi].open_load;
				end
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					ch_reg[gi] <= CH_OFF;
					retry_reg  <= 32'h0000_0000;
					ol_reg     <= 1'b0;
				end else begin
					ch_reg[gi] <= st_next;
					retry_reg  <= retry_next;
					ol_reg     <= ol_next;
				end
			end

			assign switch_on[gi]        = (ch_reg[gi] == CH_ON);
			assign fault_indication[gi] = (ch_reg[gi] == CH_FAULT);
			assign open_load_flag[gi]   = ol_reg;
			assign ch_fault_set[gi]     = (ch_reg[gi] != CH_FAULT) && (st_next == CH_FAULT);
			assign open_set[gi]         = !ol_reg && ol_next;

			a_fault_entry: assert property (@(posedge mclk) disable iff (rst)
				power_good && ch_reg[gi] == CH_ON && shutdown |=> ch_reg[gi] == CH_FAULT)
				else $error("channel missed fault entry");
			a_fault_hold: assert property (@(posedge mclk) disable iff (rst)
				power_good && ch_reg[gi] == CH_FAULT && (shutdown || latch_eff || !retry_done)
				|=> ch_reg[gi] == CH_FAULT)
				else $error("channel left fault early");
			a_fault_exit: assert property (@(posedge mclk) disable iff (rst)
				power_good && ch_reg[gi] == CH_FAULT && !shutdown && !latch_eff && retry_done
				|=> ch_reg[gi] == ($past(en_now[gi]) ? CH_ON : CH_OFF))
				else $error("wrong state after retry");
			a_open_clear: assert property (@(posedge mclk) disable iff (rst)
				power_good && en_now[gi] && !en_prev_reg[gi] |=> !ol_reg)
				else $error("open-load flag kept after enable rise");
			c_retry: cover property (@(posedge mclk) disable iff (rst)
				ch_reg[gi] == CH_FAULT ##1 ch_reg[gi] == CH_ON);
		end
	endgenerate

	// Avalon slave: one wait state, then a write with byteenable[0] set lands and read data stands
	assign waitrequest = (read | write) & ~resp_reg;
	assign bus_wr      = write & resp_reg & byteenable[0];
	assign events      = {mode_reg != MODE_STANDBY && mode_next == MODE_STANDBY,
		open_set, ch_fault_set};

	always_comb begin
		resp_next       = (read | write) & ~resp_reg;
		rdata_next      = rdata_reg;
		ctrl_latch_next = ctrl_latch_reg;
		irq_mask_next   = irq_mask_reg;
		irq_stat_next   = irq_stat_reg;
		if (read && !resp_reg) begin
			rdata_next = 32'h0000_0000;
			unique case (address)
				CTRL_OFS:       rdata_next[CTRL_LATCH_BIT] = ctrl_latch_reg;
				STATUS_OFS: begin
					rdata_next[ST_MODE_LSB +: 3] = mode_reg;
					rdata_next[ST_CH0_LSB +: 2]  = ch_reg[0];
					rdata_next[ST_CH1_LSB +: 2]  = ch_reg[1];
					rdata_next[ST_OPEN_LSB +: 2] = open_load_flag;
				end
				IRQ_STATUS_OFS: rdata_next[IRQ_W-1:0] = irq_stat_reg;
				IRQ_MASK_OFS:   rdata_next[IRQ_W-1:0] = irq_mask_reg;
				default:        rdata_next = 32'h0000_0000;
			endcase
		end
		if (bus_wr && address == CTRL_OFS) begin
			ctrl_latch_next = writedata[CTRL_LATCH_BIT];
		end
		if (bus_wr && address == IRQ_MASK_OFS) begin
			irq_mask_next = writedata[IRQ_W-1:0];
		end
		if (bus_wr && address == IRQ_STATUS_OFS) begin
			irq_stat_next = irq_stat_reg & ~writedata[IRQ_W-1:0];
		end
		// Set after clear so a same-cycle event is never lost
		irq_stat_next = irq_stat_next | events;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			resp_reg       <= 1'b0;
			rdata_reg      <= 32'h0000_0000;
			ctrl_latch_reg <= CTRL_RST;
			irq_mask_reg   <= IRQ_MASK_RST;
			irq_stat_reg   <= '0;
		end else begin
			resp_reg       <= resp_next;
			rdata_reg      <= rdata_next;
			ctrl_latch_reg <= ctrl_latch_next;
			irq_mask_reg   <= irq_mask_next;
			irq_stat_reg   <= irq_stat_next;
		end
	end

	assign readdata = rdata_reg;
	assign irq      = |(irq_stat_reg & irq_mask_reg);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_power_off: assert property (!power_good |=> mode_reg == MODE_OFF && switch_on == 2'b00)
		else $error("device not off without power");
	a_standby_quiet: assert property (mode_reg == MODE_STANDBY |-> open_load_flag == 2'b00)
		else $error("diagnostic flag alive in standby");
	a_diag_entry: assert property (power_good && diagnostic_enable && en_now == 2'b00
		|=> mode_reg == MODE_DIAG && switch_on == 2'b00)
		else $error("diagnostic state not taken");
	a_delay_entry: assert property (power_good && en_now == 2'b00 && !diagnostic_enable
		&& (mode_reg == MODE_ACTIVE || mode_reg == MODE_DIAG) |=> mode_reg == MODE_STBY_DL)
		else $error("standby delay not entered");
	a_standby_entry: assert property (power_good && en_now == 2'b00 && !diagnostic_enable
		&& mode_reg == MODE_STBY_DL && stby_done |=> mode_reg == MODE_STANDBY)
		else $error("standby not reached after delay");
	a_standby_early: assert property (mode_reg == MODE_STBY_DL && !stby_done
		|=> mode_reg != MODE_STANDBY)
		else $error("standby reached before delay");
	a_active_mode: assert property (power_good && en_now != 2'b00 |=> mode_reg == MODE_ACTIVE)
		else $error("active state not held");
	a_diag_toggle: assert property (mode_reg == MODE_ACTIVE && power_good && en_now != 2'b00
		&& $changed(diagnostic_enable) |=> mode_reg == MODE_ACTIVE)
		else $error("diag change left active state");
	a_ch_isolate: assert property (power_good && ch_reg[0] == CH_ON && en_now[0]
		&& !g_ch[0].shutdown && ch_reg[1] == CH_FAULT |=> ch_reg[0] == CH_ON)
		else $error("fault on one channel disturbed the other");
	a_irq_level: assert property (irq_stat_reg[IRQ_FAULT_LSB] && irq_mask_reg[IRQ_FAULT_LSB]
		|-> irq)
		else $error("masked-in status did not raise irq");

	c_standby: cover property (mode_reg == MODE_STBY_DL ##1 mode_reg == MODE_STANDBY);
	c_abort: cover property (mode_reg == MODE_STBY_DL ##1 mode_reg == MODE_ACTIVE);
	c_open_load: cover property (mode_reg == MODE_DIAG && open_load_flag != 2'b00);
	c_both_on: cover property (switch_on == 2'b11);

endmodule

/* design/switch_mode_pkg.sv */
// Shared constants and types for the dual high-side switch mode controller.
// Assumes a single 20 MHz clock and an Avalon-MM register slave.
package switch_mode_pkg;

	// Clock and timing
	localparam int unsigned CLK_MHZ          = 20;
	localparam int unsigned STANDBY_DELAY_US = 1500;
	localparam int unsigned RETRY_US         = 2000;
	localparam int unsigned STANDBY_CYCLES   = STANDBY_DELAY_US * CLK_MHZ;
	localparam int unsigned RETRY_CYCLES     = RETRY_US * CLK_MHZ;

	// Register byte offsets
	localparam logic [3:0] CTRL_OFS       = 4'h0;
	localparam logic [3:0] STATUS_OFS     = 4'h4;
	localparam logic [3:0] IRQ_STATUS_OFS = 4'h8;
	localparam logic [3:0] IRQ_MASK_OFS   = 4'hc;

	// Field positions
	localparam int CTRL_LATCH_BIT  = 0;
	localparam int ST_MODE_LSB     = 0;
	localparam int ST_CH0_LSB      = 3;
	localparam int ST_CH1_LSB      = 5;
	localparam int ST_OPEN_LSB     = 7;
	localparam int IRQ_FAULT_LSB   = 0;
	localparam int IRQ_OPEN_LSB    = 2;
	localparam int IRQ_STANDBY_BIT = 4;
	localparam int IRQ_W           = 5;

	// Reset values
	localparam logic             CTRL_RST     = 1'b0;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

	typedef enum logic [2:0] {
		MODE_OFF     = 3'b000,
		MODE_STANDBY = 3'b001,
		MODE_STBY_DL = 3'b010,
		MODE_DIAG    = 3'b011,
		MODE_ACTIVE  = 3'b100
	} mode_type;

	typedef enum logic [1:0] {
		CH_OFF   = 2'b00,
		CH_ON    = 2'b01,
		CH_FAULT = 2'b10
	} ch_type;

	// Per-channel analog condition flags, already digitised
	typedef struct packed {
		logic thermal_shutdown;
		logic current_limit;
		logic open_load;
	} chan_fault_type;

endpackage

/* testbench/switch_host_model.sv */
// Host microcontroller model: drives the enable, diagnostic and latch pins.
// Assumes the pins are sampled by the switch on rising mclk edges.
`timescale 1ns/1ns

module switch_host_model #(
	parameter int unsigned SETTLE_CYCLES = 4
) (
	// Clock
	input  wire logic       mclk,
	// Pins toward the switch
	output logic            channel_one_enable,
	output logic            channel_two_enable,
	output logic            diagnostic_enable,
	output logic            latch_select,
	// Switch state seen through the host's sense input
	input  wire logic [1:0] switch_on,
	input  wire logic [1:0] fault_indication
);
	logic [3:0] pins_reg = 4'h0;
	logic [7:0] settle_cnt [2] = '{8'h00, 8'h00};

	assign {channel_one_enable, channel_two_enable, diagnostic_enable, latch_select} = pins_reg;

	// Cycles since each switch closed, saturating; every fresh turn-on restarts the wait
	always @(posedge mclk) begin
		for (int c = 0; c < 2; c++) begin
			if (!switch_on[c])
				settle_cnt[c] <= 8'h00;
			else if (settle_cnt[c] != 8'(SETTLE_CYCLES))
				settle_cnt[c] <= settle_cnt[c] + 8'h01;
		end
	end

	// Plain GPIO levels, changed just after an edge so the switch never sees a race
	task automatic set_pins(input logic [3:0] p);
		@(posedge mclk);
		pins_reg <= p;
	endtask

	// Converter stand-in: a channel's fault level is taken only once its switch has settled,
	// so short on-times are never sampled early; 2'b11 means the wait ran out
	task automatic sense_sample(input int c, output logic [1:0] v);
		v = 2'b11;
		for (int i = 0; i < 40; i++) begin
			@(posedge mclk);
			if (settle_cnt[c] == 8'(SETTLE_CYCLES)) begin
				v = {1'b0, fault_indication[c]};
				return;
			end
		end
	endtask
endmodule

/* testbench/dual_switch_mode_control_tb_top.sv */
// Self-checking bench for the dual switch mode controller.
// Assumes short timer counts (8 and 6) so standby and retry finish quickly.
`timescale 1ns/1ns

module dual_switch_mode_control_tb_top;
	import switch_mode_pkg::*;

	logic                    mclk = 1'b0;
	logic                    rst = 1'b1;
	logic                    power_good = 1'b1;
	chan_fault_type [1:0]    chan_fault = '0;
	logic            [3:0]   address = 4'h0;
	logic                    read = 1'b0;
	logic                    write = 1'b0;
	logic            [31:0]  writedata = 32'h0;
	logic            [3:0]   byteenable = 4'h0;
	logic                    en1, en2, diag, latch;
	logic            [1:0]   switch_on, fault_indication, open_load_flag;
	mode_type                mode;
	logic            [31:0]  readdata;
	logic                    waitrequest, irq;
	int                      miscompares = 0;
	int                      total_checks = 0;
	int                      n;

	always #25 mclk = ~mclk;

	switch_host_model host (.mclk(mclk), .channel_one_enable(en1), .channel_two_enable(en2),
		.diagnostic_enable(diag), .latch_select(latch), .switch_on(switch_on),
		.fault_indication(fault_indication));

	dual_switch_mode_control #(.STANDBY_COUNT(8), .RETRY_COUNT(6)) dut (.mclk(mclk), .rst(rst),
		.channel_one_enable(en1), .channel_two_enable(en2), .diagnostic_enable(diag),
		.latch_select(latch), .power_good(power_good), .chan_fault(chan_fault),
		.switch_on(switch_on), .fault_indication(fault_indication),
		.open_load_flag(open_load_flag), .mode(mode), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq));

	task automatic complete_run;
		if (miscompares == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask

	// One Avalon access; the request stands until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int i;
		@(posedge mclk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		byteenable <= be;
		for (i = 0; i < 10; i++) begin
			@(posedge mclk);
			if (waitrequest === 1'b0)
				break;
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (i == 10) begin
			miscompares++;
			complete_run;
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		logic [31:0] q;
		bus(1'b1, a, d, be, q);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hf, q);
		chk(q & m, exp);
	endtask

	function automatic logic [31:0] pick(input int s);
		case (s)
			0: return 32'(mode);
			1: return 32'(switch_on);
			2: return 32'(fault_indication);
			default: return 32'(open_load_flag);
		endcase
	endfunction

	// Bounded wait on an output; running out of cycles ends the run as a failure
	task automatic wait_for(input int s, input logic [31:0] exp, output int k);
		for (k = 1; k <= 40; k++) begin
			tick(1);
			if (pick(s) === exp)
				return;
		end
		chk(pick(s), exp);
		complete_run;
	endtask

	task automatic s_regs;
		rd(CTRL_OFS, 32'h1, 32'h0);
		rd(IRQ_MASK_OFS, 32'h1f, 32'h0);
		rd(4'h2, 32'hffffffff, 32'h0);
		wr(IRQ_MASK_OFS, 32'h1f, 4'h0);
		rd(IRQ_MASK_OFS, 32'h1f, 32'h0);
		wr(IRQ_MASK_OFS, 32'hffff_ffff, 4'he);
		rd(IRQ_MASK_OFS, 32'h1f, 32'h0);
		rd(4'hd, 32'hffffffff, 32'h0);
	endtask

	task automatic s_standby;
		host.set_pins(4'b0010);
		wait_for(0, MODE_DIAG, n);
		chk(32'(switch_on), 32'h0);
		host.set_pins(4'b0000);
		wait_for(0, MODE_STBY_DL, n);
		tick(3);
		host.set_pins(4'b0010);
		wait_for(0, MODE_DIAG, n);
		host.set_pins(4'b0000);
		wait_for(0, MODE_STBY_DL, n);
		wait_for(0, MODE_STANDBY, n);
		chk(32'(n), 32'h8);
		chk(32'(open_load_flag), 32'h0);
		rd(IRQ_STATUS_OFS, 32'h10, 32'h10);
		chk(32'(irq), 32'h0);
		wr(IRQ_MASK_OFS, 32'h10, 4'h1);
		tick(0);
		chk(32'(irq), 32'h1);
		wr(IRQ_STATUS_OFS, 32'h10, 4'h1);
		tick(0);
		chk(32'(irq), 32'h0);
		wr(IRQ_MASK_OFS, 32'h0, 4'h1);
	endtask

	task automatic s_active;
		logic [1:0] v;
		host.set_pins(4'b1000);
		wait_for(1, 32'h1, n);
		host.sense_sample(0, v);
		chk(32'(v), 32'h0);
		if (v === 2'b11)
			complete_run;
		chk(32'(mode), 32'(MODE_ACTIVE));
		host.set_pins(4'b1010);
		tick(3);
		chk(32'(mode), 32'(MODE_ACTIVE));
		host.set_pins(4'b0100);
		wait_for(1, 32'h2, n);
		chk(32'(mode), 32'(MODE_ACTIVE));
	endtask

	task automatic s_fault;
		host.set_pins(4'b1101);
		wait_for(1, 32'h3, n);
		@(posedge mclk);
		chan_fault[0].current_limit <= 1'b1;
		wait_for(2, 32'h1, n);
		chk(32'(switch_on), 32'h2);
		@(posedge mclk);
		chan_fault[0].current_limit <= 1'b0;
		tick(20);
		chk(32'(fault_indication), 32'h1);
		host.set_pins(4'b1100);
		wait_for(1, 32'h3, n);
		chk(32'(fault_indication), 32'h0);
		rd(IRQ_STATUS_OFS, 32'h3, 32'h1);
		wr(IRQ_STATUS_OFS, 32'h3, 4'h1);
		@(posedge mclk);
		chan_fault[1].thermal_shutdown <= 1'b1;
		wait_for(2, 32'h2, n);
		host.set_pins(4'b1000);
		tick(20);
		chk(32'(fault_indication), 32'h2);
		chk(32'(switch_on), 32'h1);
		@(posedge mclk);
		chan_fault[1].thermal_shutdown <= 1'b0;
		tick(20);
		chk(32'(switch_on), 32'h1);
		chk(32'(fault_indication), 32'h0);
	endtask

	task automatic s_open_load;
		host.set_pins(4'b0010);
		@(posedge mclk);
		chan_fault[0].open_load <= 1'b1;
		wait_for(3, 32'h1, n);
		host.set_pins(4'b0000);
		wait_for(3, 32'h0, n);
		chk(32'(n), 32'h1);
		host.set_pins(4'b0010);
		wait_for(3, 32'h1, n);
		host.set_pins(4'b1010);
		wait_for(3, 32'h0, n);
		chk(32'(n), 32'h1);
		@(posedge mclk);
		chan_fault[0].open_load <= 1'b0;
	endtask

	// Software latch, the remaining fault inputs, channel two open load and fault irq
	task automatic s_latch;
		wr(CTRL_OFS, 32'hffff_ffff, 4'hf);
		rd(CTRL_OFS, 32'hffff_ffff, 32'h1);
		@(posedge mclk);
		chan_fault[0].thermal_shutdown <= 1'b1;
		chan_fault[1].open_load <= 1'b1;
		wait_for(2, 32'h1, n);
		wait_for(3, 32'h2, n);
		@(posedge mclk);
		chan_fault[0].thermal_shutdown <= 1'b0;
		chan_fault[1].open_load <= 1'b0;
		tick(20);
		chk(32'(fault_indication), 32'h1);
		chk(32'(open_load_flag), 32'h0);
		wr(CTRL_OFS, 32'h0, 4'h1);
		wait_for(1, 32'h1, n);
		rd(IRQ_STATUS_OFS, 32'h1f, 32'h0f);
		wr(IRQ_MASK_OFS, 32'h1, 4'h1);
		tick(0);
		chk(32'(irq), 32'h1);
		wr(IRQ_STATUS_OFS, 32'hffff_ffff, 4'h1);
		tick(0);
		chk(32'(irq), 32'h0);
		host.set_pins(4'b0110);
		wait_for(1, 32'h2, n);
		@(posedge mclk);
		chan_fault[1].current_limit <= 1'b1;
		wait_for(2, 32'h2, n);
		@(posedge mclk);
		chan_fault[1].current_limit <= 1'b0;
		wait_for(1, 32'h2, n);
		rd(IRQ_STATUS_OFS, 32'h1f, 32'h02);
		wr(IRQ_STATUS_OFS, 32'h1f, 4'h1);
		wr(IRQ_MASK_OFS, 32'h0, 4'h1);
	endtask

	task automatic s_power;
		@(posedge mclk);
		power_good <= 1'b0;
		wait_for(0, MODE_OFF, n);
		chk(32'(switch_on), 32'h0);
		@(posedge mclk);
		power_good <= 1'b1;
		wait_for(0, MODE_ACTIVE, n);
		@(posedge mclk);
		rst <= 1'b1;
		tick(3);
		chk(32'(mode), 32'(MODE_OFF));
		chk(32'(switch_on), 32'h0);
		chk(readdata, 32'h0);
		chk(32'(irq), 32'h0);
		@(posedge mclk);
		rst <= 1'b0;
		wait_for(0, MODE_ACTIVE, n);
		chk(32'(n), 32'h1);
	endtask

	initial begin
		tick(2);
		chk(32'(mode), 32'(MODE_OFF));
		chk(32'(irq), 32'h0);
		@(posedge mclk);
		rst <= 1'b0;
		s_regs;
		s_standby;
		s_active;
		s_fault;
		s_open_load;
		s_latch;
		s_power;
		complete_run;
	end
endmodule
